//--- design/osc_config_and_battery_switch_ctrl.sv
// oscillator config and supply switch-over control with register port
`timescale 1ns/100ps
module osc_config_and_battery_switch_ctrl #(
   parameter int PULSE_LEN = pwr_osc_pkg::PULSE_CYC
) (
   input  wire logic       sys_clk_i,          // 100 MHz clock
   input  wire logic       nrst_i,             // async reset, active low
   input  wire logic       reg_wr_i,           // register write strobe
   input  wire logic       reg_rd_i,           // register read strobe
   input  wire logic [7:0] reg_addr_i,         // register address
   input  wire logic [7:0] reg_wdata_i,        // write data
   output logic      [7:0] reg_rdata_o,        // read data
   output logic            reg_ack_o,          // access accepted
   input  wire logic       flag_clr_i,         // clear switch-over flag
   input  wire logic       switchover_irq_en_first_i,  // battery irq en, first
   input  wire logic       switchover_irq_en_second_i, // battery irq en, second
   input  wire logic       irq_level_mode_i,   // 1 level, 0 pulse
   input  wire logic       vdd_gt_vth_i,       // comparator: supply above threshold
   input  wire logic       vdd_gt_vbat_i,      // comparator: supply above battery
   input  wire logic       vbat_gt_vth_i,      // comparator: battery above threshold
   input  wire logic       clk_out_i,          // clock to be output
   input  wire logic       stamp_pin_i,        // stamp pin digital input
   input  wire logic       stamp_sw_i,         // mechanical switch detector input
   input  wire logic       clk_fn_first_i,     // first irq pin in clock mode
   output logic            switchover_flag_o,  // sticky flag
   output logic            on_battery_o,       // running from battery
   output logic            low_jitter_sel_o,   // reduced jitter mode
   output logic      [1:0] osc_drive_level_o,  // decoded drive level
   output logic      [1:0] load_cap_sel_o,     // decoded load capacitor
   output logic            switchover_refresh_rate_o, // refresh rate
   output logic            switchover_threshold_sel_o, // 0 1.5V, 1 2.8V
   output logic            bus_en_o,           // i2c pins honoured
   output logic            clk_pin_o,          // clock pin output
   output logic            clk_pin_oe_n_o,     // clock pin enable, low drives
   output logic            stamp_pin_o,        // stamp pin output
   output logic            stamp_pin_oe_n_o,   // stamp pin enable, low drives
   output logic            stamp_in_o,         // gated stamp digital input
   output logic            stamp_sw_o,         // switch detector, always live
   output logic            irq_out_first_o,    // first irq pin value
   output logic            irq_out_first_oe_n_o, // open drain, low drives
   output logic            irq_out_second_o,   // second irq, active low
   output logic            irq_out_second_oe_n_o // low drives
);
   // ------------------------------------------------------------
   // reset and input synchronisers
   // ------------------------------------------------------------
   logic       rst_s1_r, rst_n;
   logic [3:0] cmp_s1_r, cmp_s2_r;
   logic [1:0] ts_s1_r, ts_s2_r;

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // start as main good: reset must not fake a battery entry
         cmp_s1_r <= 4'he;
         cmp_s2_r <= 4'he;
         ts_s1_r  <= 2'h0;
         ts_s2_r  <= 2'h0;
      end
      else
      begin
         cmp_s1_r <= {vbat_gt_vth_i, vdd_gt_vbat_i, vdd_gt_vth_i, 1'b0};
         cmp_s2_r <= cmp_s1_r;
         ts_s1_r  <= {stamp_pin_i, stamp_sw_i};
         ts_s2_r  <= ts_s1_r;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] osc_r, psw_r;
   logic       on_batt_r, flag_r;
   logic       acc_ok;

   assign acc_ok = !on_batt_r;  // RULE10 RULE13

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_r <= pwr_osc_pkg::OSC_CTRL_RESET;
         psw_r <= pwr_osc_pkg::PWR_SW_RESET;
      end
      else if (reg_wr_i && acc_ok)
      begin
         if (reg_addr_i == pwr_osc_pkg::OSC_CTRL_ADDR)
            osc_r <= reg_wdata_i;
         else if (reg_addr_i == pwr_osc_pkg::PWR_SW_ADDR)
            psw_r <= reg_wdata_i & pwr_osc_pkg::PWR_SW_WMASK;  // RULE16 RULE6
      end
   end

   // unmapped addresses read zero; nothing answers on battery
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i && acc_ok)
      begin
         if (reg_addr_i == pwr_osc_pkg::OSC_CTRL_ADDR)
            reg_rdata_o <= osc_r;
         else if (reg_addr_i == pwr_osc_pkg::PWR_SW_ADDR)
            reg_rdata_o <= psw_r;  // RULE16
         else
            reg_rdata_o <= 8'h00;
      end
   end

   assign reg_ack_o = (reg_rd_i || reg_wr_i) && acc_ok;  // RULE10

   // ------------------------------------------------------------
   // oscillator and switch-over field decode
   // ------------------------------------------------------------
   function automatic logic [1:0] fold_high(input logic [1:0] f);
      fold_high = f[1] ? 2'b10 : f;  // 10 and 11 share one setting
   endfunction

   assign low_jitter_sel_o  = osc_r[pwr_osc_pkg::LOW_JITTER_BIT];  // RULE1
   assign osc_drive_level_o = fold_high(osc_r[pwr_osc_pkg::DRIVE_LSB +: 2]);  // RULE2
   assign load_cap_sel_o    = fold_high(osc_r[pwr_osc_pkg::LOAD_CAP_LSB +: 2]);  // RULE3
   assign switchover_refresh_rate_o  = psw_r[pwr_osc_pkg::SW_REFRESH_BIT];  // RULE6
   assign switchover_threshold_sel_o = psw_r[pwr_osc_pkg::SW_THRESH_BIT];  // RULE17

   // ------------------------------------------------------------
   // supply selection
   // ------------------------------------------------------------
   logic       main_ok;
   logic       dis;
   logic [1:0] mode;

   assign dis  = psw_r[pwr_osc_pkg::SW_DISABLE_BIT];  // RULE5
   assign mode = psw_r[pwr_osc_pkg::SW_MODE_LSB +: 2];

   // comparator sees threshold already picked by the select bit
   always_comb
   begin
      case (mode)  // RULE7
         pwr_osc_pkg::MODE_THRESH: main_ok = cmp_s2_r[1];
         pwr_osc_pkg::MODE_BATT:   main_ok = cmp_s2_r[2];
         pwr_osc_pkg::MODE_HIGHER: main_ok = cmp_s2_r[1] && cmp_s2_r[2];
         pwr_osc_pkg::MODE_LOWER:  main_ok = cmp_s2_r[1] || cmp_s2_r[2];
         default:                  main_ok = 1'b1;
      endcase
   end

   logic to_batt, to_main;

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         on_batt_r <= 1'b0;
      else
         on_batt_r <= !dis && !main_ok;  // RULE8 RULE5
   end

   logic on_batt_d_r;
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         on_batt_d_r <= 1'b0;
      else
         on_batt_d_r <= on_batt_r;
   end

   assign to_batt = on_batt_r && !on_batt_d_r;
   assign to_main = !on_batt_r && on_batt_d_r;

   // set wins over clear
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         flag_r <= 1'b0;
      else if (to_batt)
         flag_r <= 1'b1;  // RULE9
      else if (flag_clr_i && acc_ok)
         flag_r <= 1'b0;  // RULE18
   end

   assign switchover_flag_o = flag_r;
   assign on_battery_o      = on_batt_r;

   // ------------------------------------------------------------
   // interrupts and pin gating
   // ------------------------------------------------------------
   logic pulse;

   irq_pulse_gen #(
      .LEN (PULSE_LEN)
   ) u_pulse (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n),
      .trig_i    (to_batt || to_main),  // RULE19 RULE12
      .pulse_o   (pulse)
   );

   logic irq_act;
   assign irq_act = irq_level_mode_i ? flag_r : pulse;  // RULE11

   // first pin: interrupts survive battery, clock function does not
   always_comb
   begin
      irq_out_first_o = 1'b0;
      if (clk_fn_first_i && !on_batt_r)
         irq_out_first_oe_n_o = clk_out_i;  // drives low when clock low
      else
         irq_out_first_oe_n_o = !(switchover_irq_en_first_i && irq_act);  // RULE15
   end

   assign irq_out_second_o      = !(switchover_irq_en_second_i && irq_act);
   assign irq_out_second_oe_n_o = on_batt_r;  // RULE20

   assign bus_en_o         = !on_batt_r;  // RULE13
   assign clk_pin_o        = clk_out_i;
   assign clk_pin_oe_n_o   = on_batt_r;  // RULE13
   assign stamp_pin_o      = irq_out_second_o;
   assign stamp_pin_oe_n_o = on_batt_r;  // RULE13
   assign stamp_in_o       = ts_s2_r[1] && !on_batt_r;  // RULE13
   assign stamp_sw_o       = ts_s2_r[0];  // RULE14
endmodule

//--- design/pwr_osc_pkg.sv
// constants for oscillator control and supply switch-over registers
// Overview of operation
// RULE1: bit 4 selects low-jitter clock output
// RULE2: drive field 00 normal, 01 low, 1x high
// RULE3: load cap 00 7pF, 01 6pF, 1x 12.5pF
// RULE4: software sets 7pF for 9pF crystal
// RULE5: bit 4 set disables whole switch-over
// RULE6: bit 3 holds refresh rate, keep default
// RULE7: mode field picks threshold, battery, max, min
// RULE8: main supply above level, else battery
// RULE9: main to battery sets the flag
// RULE10: no register access on battery
// RULE11: battery entry raises pulse or level irq
// RULE12: return to main raises irq pulse
// RULE13: battery blocks bus, clock, stamp pin
// RULE14: switch detector stays active always
// RULE15: first irq output keeps irq, drops clock
// RULE16: upper three bits read zero
// RULE17: bit 0 selects 1.5V or 2.8V threshold
// RULE18: flag stays set until cleared
// RULE19: irq on every transition, flag regardless
// RULE20: second irq output only on main supply
package pwr_osc_pkg;
   localparam logic [7:0] OSC_CTRL_ADDR   = 8'h25;
   localparam logic [7:0] PWR_SW_ADDR     = 8'h26;
   localparam logic [7:0] OSC_CTRL_RESET  = 8'h00;
   localparam logic [7:0] PWR_SW_RESET    = 8'h00;
   localparam int         LOW_JITTER_BIT  = 4;
   localparam int         DRIVE_LSB       = 2;
   localparam int         LOAD_CAP_LSB    = 0;
   localparam int         SW_DISABLE_BIT  = 4;
   localparam int         SW_REFRESH_BIT  = 3;
   localparam int         SW_MODE_LSB     = 1;
   localparam int         SW_THRESH_BIT   = 0;
   localparam logic [7:0] PWR_SW_WMASK    = 8'h1f;
   localparam int         PULSE_NS        = 7_812_500;  // one 128 Hz period
   localparam int         CLK_NS          = 10;
   localparam int         PULSE_CYC       = PULSE_NS / CLK_NS;

   typedef enum logic [1:0] {
      DRV_NORMAL = 2'b00,
      DRV_LOW    = 2'b01,
      DRV_HIGH   = 2'b10
   } drive_e;

   typedef enum logic [1:0] {
      CAP_7P0  = 2'b00,
      CAP_6P0  = 2'b01,
      CAP_12P5 = 2'b10
   } cap_e;

   typedef enum logic [1:0] {
      MODE_THRESH = 2'b00,
      MODE_BATT   = 2'b01,
      MODE_HIGHER = 2'b10,
      MODE_LOWER  = 2'b11
   } sw_mode_e;
endpackage

//--- design/irq_pulse_gen.sv
// stretches a trigger into a fixed-length active-high pulse
`timescale 1ns/100ps
module irq_pulse_gen #(
   parameter int LEN = pwr_osc_pkg::PULSE_CYC
) (
   input  wire logic sys_clk_i,   // system clock
   input  wire logic rst_n_i,     // synchronised reset
   input  wire logic trig_i,      // one-cycle trigger
   output logic      pulse_o      // stretched pulse
);
   logic [22:0] cnt_r;

   // a new trigger restarts the count, so events within LEN cycles merge into one longer pulse
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_r <= 23'h00_0000;
      else if (trig_i)
         cnt_r <= 23'(LEN);
      else if (cnt_r != 23'h00_0000)
         cnt_r <= cnt_r - 23'h00_0001;
   end

   assign pulse_o = (cnt_r != 23'h00_0000);
endmodule

//--- verif/supply_cmp_model.sv
// comparator model of main supply, battery and threshold levels
`timescale 1ns/100ps
module supply_cmp_model (
   input  wire logic [15:0] vdd_mv_i,      // main supply level in mV
   input  wire logic [15:0] vbat_mv_i,     // battery level in mV
   input  wire logic        thr_sel_i,     // threshold select from the block
   output logic             vdd_gt_vth_o,  // supply above threshold
   output logic             vdd_gt_vbat_o, // supply above battery
   output logic             vbat_gt_vth_o  // battery above threshold
);
   logic [15:0] vth_mv;

   assign vth_mv        = thr_sel_i ? 16'h0af0 : 16'h05dc;
   assign vdd_gt_vth_o  = vdd_mv_i > vth_mv;
   assign vdd_gt_vbat_o = vdd_mv_i > vbat_mv_i;
   assign vbat_gt_vth_o = vbat_mv_i > vth_mv;
endmodule

//--- verif/osc_ctrl_props.sv
// assertions on the switch-over control ports
`timescale 1ns/100ps
module osc_ctrl_props #(
   parameter int PULSE_LEN = 8
) (
   input wire logic       sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, reg_ack_o, flag_clr_i,
   input wire logic       switchover_irq_en_first_i, irq_level_mode_i, clk_fn_first_i,
   input wire logic       stamp_sw_i, stamp_sw_o, switchover_flag_o, on_battery_o, bus_en_o,
   input wire logic       clk_pin_oe_n_o, stamp_pin_oe_n_o, irq_out_first_oe_n_o,
   input wire logic       irq_out_second_oe_n_o,
   input wire logic [1:0] osc_drive_level_o, load_cap_sel_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_enter;
      $rose(on_battery_o);
   endsequence
   sequence s_leave;
      $fell(on_battery_o);
   endsequence
   sequence s_armed;
      switchover_irq_en_first_i && !irq_level_mode_i && !clk_fn_first_i;
   endsequence
   a_access_gate: assert property ((reg_wr_i || reg_rd_i) |-> reg_ack_o == !on_battery_o)
      else $error("access acknowledge wrong for supply state");
   a_flag_on_entry: assert property (s_enter |=> switchover_flag_o)
      else $error("flag not set on battery entry");
   a_flag_sticky: assert property (switchover_flag_o && !flag_clr_i |=> switchover_flag_o)
      else $error("flag dropped without clear");
   a_battery_pins: assert property (on_battery_o |-> !bus_en_o && clk_pin_oe_n_o && stamp_pin_oe_n_o)
      else $error("pins still live on battery");
   a_second_irq_off: assert property (on_battery_o |-> irq_out_second_oe_n_o)
      else $error("second irq driven on battery");
   a_drive_decode: assert property (osc_drive_level_o != 2'h3)
      else $error("drive level code out of range");
   a_cap_decode: assert property (load_cap_sel_o != 2'h3)
      else $error("load cap code out of range");
   a_pulse_entry: assert property (s_enter ##0 s_armed |=> !irq_out_first_oe_n_o [*4])
      else $error("no irq pulse on battery entry");
   a_pulse_return: assert property (s_leave ##0 s_armed |=> !irq_out_first_oe_n_o [*4])
      else $error("no irq pulse on return to main");
   a_level_irq: assert property ((irq_level_mode_i && switchover_irq_en_first_i
      && switchover_flag_o && !clk_fn_first_i) [*2] |-> !irq_out_first_oe_n_o)
      else $error("level irq not following flag");
   a_detector_live: assert property ((on_battery_o && stamp_sw_i) [*3] |-> stamp_sw_o)
      else $error("switch detector dead on battery");
endmodule
bind osc_config_and_battery_switch_ctrl osc_ctrl_props #(.PULSE_LEN(PULSE_LEN)) u_osc_ctrl_props (
   .sys_clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_ack_o, .flag_clr_i, .switchover_irq_en_first_i,
   .irq_level_mode_i, .clk_fn_first_i, .stamp_sw_i, .stamp_sw_o, .switchover_flag_o,
   .on_battery_o, .bus_en_o, .clk_pin_oe_n_o, .stamp_pin_oe_n_o, .irq_out_first_oe_n_o,
   .irq_out_second_oe_n_o, .osc_drive_level_o, .load_cap_sel_o);

//--- verif/test_osc_config_and_battery_switch_ctrl.sv
// self-checking bench for oscillator config and supply switch-over control
`timescale 1ns/100ps
module test_osc_config_and_battery_switch_ctrl;
   localparam int PULSE_LEN = 8;
   logic        sys_clk_i = 1'h0, nrst_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
   logic        flag_clr_i = 1'h0, irq_level_mode_i = 1'h0, stamp_sw_i = 1'h0;
   logic        clk_fn_first_i = 1'h0, clk_out_i = 1'h0, stamp_pin_i = 1'h0;
   logic        switchover_irq_en_first_i = 1'h1, switchover_irq_en_second_i = 1'h1;
   logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [15:0] vdd_mv = 16'h0ce4, vbat_mv = 16'h0bb8;
   logic        reg_ack_o, vdd_gt_vth_i, vdd_gt_vbat_i, vbat_gt_vth_i, switchover_flag_o;
   logic        on_battery_o, low_jitter_sel_o, switchover_refresh_rate_o;
   logic        switchover_threshold_sel_o, bus_en_o, irq_out_first_oe_n_o;
   logic        irq_out_first_o, irq_out_second_o, irq_out_second_oe_n_o, clk_pin_o;
   logic        clk_pin_oe_n_o, stamp_pin_o, stamp_pin_oe_n_o, stamp_in_o, stamp_sw_o;
   logic [1:0]  osc_drive_level_o, load_cap_sel_o;
   int          mismatches = 0, check_count = 0;

   osc_config_and_battery_switch_ctrl #(.PULSE_LEN(PULSE_LEN))
      u_osc_config_and_battery_switch_ctrl (
      .sys_clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
      .reg_ack_o, .flag_clr_i, .switchover_irq_en_first_i, .switchover_irq_en_second_i,
      .irq_level_mode_i, .vdd_gt_vth_i, .vdd_gt_vbat_i, .vbat_gt_vth_i, .clk_out_i,
      .stamp_pin_i, .stamp_sw_i, .clk_fn_first_i, .switchover_flag_o,
      .on_battery_o, .low_jitter_sel_o, .osc_drive_level_o, .load_cap_sel_o,
      .switchover_refresh_rate_o, .switchover_threshold_sel_o, .bus_en_o, .clk_pin_o,
      .clk_pin_oe_n_o, .stamp_pin_o, .stamp_pin_oe_n_o, .stamp_in_o, .stamp_sw_o,
      .irq_out_first_o, .irq_out_first_oe_n_o, .irq_out_second_o,
      .irq_out_second_oe_n_o);
   supply_cmp_model u_supply_cmp_model (.vdd_mv_i(vdd_mv), .vbat_mv_i(vbat_mv),
      .thr_sel_i(switchover_threshold_sel_o), .vdd_gt_vth_o(vdd_gt_vth_i),
      .vdd_gt_vbat_o(vdd_gt_vbat_i), .vbat_gt_vth_o(vbat_gt_vth_i));

   always #5 sys_clk_i = ~sys_clk_i;

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one strobe cycle; ack is combinational so it is looked at before the edge
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                         input logic ack);
      @(posedge sys_clk_i);
      #1;
      reg_wr_i = wr;
      reg_rd_i = !wr;
      reg_addr_i = addr;
      reg_wdata_i = data;
      #1;
      chk("reg_ack_o", 8'(ack), 8'(reg_ack_o));
      @(posedge sys_clk_i);
      #1;
      reg_wr_i = 1'h0;
      reg_rd_i = 1'h0;
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      access(1'h0, addr, 8'h00, 1'h1);
      chk("reg_rdata_o", exp, reg_rdata_o);
   endtask
   // two sync edges, the supply edge, the flag edge and one spare
   task automatic wait_bat(input logic e);
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk("on_battery_o", 8'(e), 8'(on_battery_o));
   endtask
   task automatic pulse_clr;
      @(posedge sys_clk_i);
      #1;
      flag_clr_i = 1'h1;
      @(posedge sys_clk_i);
      #1;
      flag_clr_i = 1'h0;
   endtask

   task automatic t_osc;
      logic [1:0] d;
      logic [1:0] c;
      for (int i = 0; i < 32; i++)
      begin
         access(1'h1, pwr_osc_pkg::OSC_CTRL_ADDR, 8'(i), 1'h1);
         d = i[3] ? pwr_osc_pkg::DRV_HIGH : 2'(i[3:2]);
         c = i[1] ? pwr_osc_pkg::CAP_12P5 : 2'(i[1:0]);
         chk("low_jitter_sel_o", 8'(i[4]), 8'(low_jitter_sel_o));
         chk("osc_drive_level_o", 8'(d), 8'(osc_drive_level_o));
         chk("load_cap_sel_o", 8'(c), 8'(load_cap_sel_o));
         rd(pwr_osc_pkg::OSC_CTRL_ADDR, 8'(i));
      end
      access(1'h1, pwr_osc_pkg::OSC_CTRL_ADDR, 8'h00, 1'h1);
   endtask
   task automatic t_pwr;
      rd(pwr_osc_pkg::PWR_SW_ADDR, 8'h00);
      access(1'h1, pwr_osc_pkg::PWR_SW_ADDR, 8'hff, 1'h1);
      rd(pwr_osc_pkg::PWR_SW_ADDR, 8'h1f);
      chk("switchover_refresh_rate_o", 8'h01, 8'(switchover_refresh_rate_o));
      chk("switchover_threshold_sel_o", 8'h01, 8'(switchover_threshold_sel_o));
      rd(8'h30, 8'h00);
      access(1'h1, pwr_osc_pkg::PWR_SW_ADDR, 8'h10, 1'h1);
      vdd_mv = 16'h03e8;
      wait_bat(1'h0);
      vdd_mv = 16'h0ce4;
      access(1'h1, pwr_osc_pkg::PWR_SW_ADDR, 8'h00, 1'h1);
   endtask
   // supply between 1.5 V threshold and 3.0 V battery: modes 01 and 10 switch
   task automatic t_modes;
      logic [3:0] e;
      e = 4'h6;
      for (int m = 0; m < 4; m++)
      begin
         access(1'h1, pwr_osc_pkg::PWR_SW_ADDR, 8'(m << 1), 1'h1);
         stamp_sw_i = m[0];
         vdd_mv = 16'h07d0;
         wait_bat(e[m]);
         if (e[m])
         begin
            access(1'h0, pwr_osc_pkg::OSC_CTRL_ADDR, 8'h00, 1'h0);
            pulse_clr();
            chk("bus_en_o", 8'h00, 8'(bus_en_o));
         end
         vdd_mv = 16'h0ce4;
         wait_bat(1'h0);
         chk("switchover_flag_o", 8'(m > 0), 8'(switchover_flag_o));
      end
   endtask
   task automatic t_level;
      irq_level_mode_i = 1'h1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk("irq_out_first_oe_n_o", 8'h00, 8'(irq_out_first_oe_n_o));
      pulse_clr();
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("switchover_flag_o", 8'h00, 8'(switchover_flag_o));
      chk("irq_out_first_oe_n_o", 8'h01, 8'(irq_out_first_oe_n_o));
      irq_level_mode_i = 1'h0;
   endtask
   // clock on the first irq pin only on main; second irq gated by its enable
   task automatic t_pins;
      clk_fn_first_i = 1'h1;
      stamp_pin_i = 1'h1;
      stamp_sw_i = 1'h0;
      switchover_irq_en_second_i = 1'h0;
      access(1'h1, pwr_osc_pkg::PWR_SW_ADDR, 8'h02, 1'h1);
      chk("stamp_in_o", 8'h01, 8'(stamp_in_o));
      chk("irq_out_first_oe_n_o", 8'h00, 8'(irq_out_first_oe_n_o));
      chk("clk_pin_o", 8'h00, 8'(clk_pin_o));
      chk("clk_pin_oe_n_o", 8'h00, 8'(clk_pin_oe_n_o));
      clk_out_i = 1'h1;
      vdd_mv = 16'h07d0;
      wait_bat(1'h1);
      chk("irq_out_first_oe_n_o", 8'h00, 8'(irq_out_first_oe_n_o));
      chk("irq_out_first_o", 8'h00, 8'(irq_out_first_o));
      chk("irq_out_second_o", 8'h01, 8'(irq_out_second_o));
      chk("irq_out_second_oe_n_o", 8'h01, 8'(irq_out_second_oe_n_o));
      chk("clk_pin_oe_n_o", 8'h01, 8'(clk_pin_oe_n_o));
      chk("stamp_pin_oe_n_o", 8'h01, 8'(stamp_pin_oe_n_o));
      chk("stamp_in_o", 8'h00, 8'(stamp_in_o));
      chk("stamp_sw_o", 8'h00, 8'(stamp_sw_o));
      switchover_irq_en_second_i = 1'h1;
      vdd_mv = 16'h0ce4;
      wait_bat(1'h0);
      chk("irq_out_second_o", 8'h00, 8'(irq_out_second_o));
      chk("stamp_pin_o", 8'h00, 8'(stamp_pin_o));
      chk("irq_out_second_oe_n_o", 8'h00, 8'(irq_out_second_oe_n_o));
      chk("irq_out_first_oe_n_o", 8'h01, 8'(irq_out_first_oe_n_o));
      chk("switchover_flag_o", 8'h01, 8'(switchover_flag_o));
   endtask

   task automatic results;
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      #1;
      nrst_i = 1'h1;
      repeat (3) @(posedge sys_clk_i);
      t_osc();
      t_pwr();
      t_modes();
      t_level();
      t_pins();
      results();
   end
endmodule
